//--- hw/pid_setpoint_loop.sv
// design: pid setpoint loop with frequency reference select and apb register file
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - The loop is on only while the pid enable selector holds 01, otherwise it is idle.
// - With the loop idle the output follows the fixed setting, the pot or an analog input.
// - With the loop on the output frequency is computed here, not taken from the source.
// - The process variable comes from either the voltage or the current analog input.
// - With the loop on the output is adjusted so the loop error is driven toward zero.
// - The scale factor converts setpoint and process variable units into frequency.
// - Setpoint to output deviation is measured as a percentage of full scale.
// - At or below the limit the controller output passes unrestricted.
// - Above the limit the output is pulled back so the deviation equals the limit; a zero limit setting switches the limit off here.
// - Error is setpoint minus process variable, negated when polarity is inverted.
module pid_setpoint_loop
  import pid_pkg::*;
#(
  parameter int DW = 16,
  parameter int TICK_DIV = LOOP_TICK_CYCLES
) (
  // clock, reset and clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog samples and panel pot, already digitised
  input wire logic [DW-1:0] pot_value,
  input wire logic [DW-1:0] voltage_input,
  input wire logic [DW-1:0] current_input_pin,
  // frequency command and loop state
  output logic [DW-1:0] out_freq,
  output logic pid_active,
  output logic limit_active
);

  // sum width, full scale and last count of the tick divider
  localparam int SW = 2 * DW + 4;
  localparam logic [DW-1:0] FULL = '1;
  localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

  // elaboration check: the fixed point products need 8..24 bit samples
  if (DW < 8 || DW > 24) begin : g_bad_width
    $error("pid_setpoint_loop: DW must be 8..24");
  end

  // elaboration check: the tick counter is sixteen bits wide
  if (TICK_DIV < 1 || TICK_DIV > 65536) begin : g_bad_tick
    $error("pid_setpoint_loop: TICK_DIV must be 1..65536");
  end

  // elaboration check: the control fields share one bus word
  if (CTRL_W > 32) begin : g_bad_ctrl
    $error("pid_setpoint_loop: control field wider than the bus word");
  end

  // elaboration check: the register map must fit the address port
  if (ADDR_W < 6) begin : g_bad_addr
    $error("pid_setpoint_loop: address port too narrow for the register map");
  end

  // configuration registers
  logic [CTRL_W-1:0] ctrl_ff;
  logic [DW-1:0] fixed_freq_setting_ff;
  logic [DW-1:0] setpoint_value_ff;
  logic [DW-1:0] pv_scale_factor_ff;
  logic [DW-1:0] pid_output_limit_ff;

  // controller gains, same fixed point format as the scale factor
  logic [DW-1:0] kp_ff;
  logic [DW-1:0] ki_ff;
  logic [31:0] prdata_ff;

  // loop state
  logic [15:0] tick_cnt_ff;
  logic signed [SW-1:0] integ_ff;

  // output command and its limit flag
  logic [DW-1:0] out_freq_ff;
  logic limit_active_ff;

  // control fields
  wire logic [1:0] pid_enable_sel = ctrl_ff[CTRL_EN_LSB +: 2];
  wire logic [1:0] freq_source_sel = ctrl_ff[CTRL_SRC_LSB +: 2];
  wire logic error_polarity_sel = ctrl_ff[CTRL_POL_BIT];

  // one terminal select serves both the idle reference and the process variable
  wire logic analog_sel = ctrl_ff[CTRL_AIN_BIT];

  // apb decode
  wire logic acc = psel && penable && clk_en;
  wire logic setup = psel && !penable && clk_en;

  // address hits, one per register; a miss answers with an error
  wire logic hit_ctrl = (paddr == REG_CTRL);
  wire logic hit_fixed = (paddr == REG_FIXED);
  wire logic hit_setpt = (paddr == REG_SETPT);
  wire logic hit_scale = (paddr == REG_SCALE);
  wire logic hit_limit = (paddr == REG_LIMIT);
  wire logic hit_kp = (paddr == REG_KP);
  wire logic hit_ki = (paddr == REG_KI);
  wire logic hit_status = (paddr == REG_STATUS);
  wire logic hit_outf = (paddr == REG_OUTFREQ);
  wire logic hit_any = hit_ctrl || hit_fixed || hit_setpt || hit_scale || hit_limit
                       || hit_kp || hit_ki || hit_status || hit_outf;
  wire logic wr = acc && pwrite;
  wire logic [DW-1:0] wdat = pwdata[DW-1:0];

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[CTRL_W-1:0] = ctrl_ff;
    end else if (hit_fixed) begin
      rd_mux[DW-1:0] = fixed_freq_setting_ff;
    end else if (hit_setpt) begin
      rd_mux[DW-1:0] = setpoint_value_ff;
    end else if (hit_scale) begin
      rd_mux[DW-1:0] = pv_scale_factor_ff;
    end else if (hit_limit) begin
      rd_mux[DW-1:0] = pid_output_limit_ff;
    end else if (hit_kp) begin
      rd_mux[DW-1:0] = kp_ff;
    end else if (hit_ki) begin
      rd_mux[DW-1:0] = ki_ff;
    end else if (hit_status) begin
      rd_mux[STAT_ACTIVE_BIT] = pid_active;
      rd_mux[STAT_LIMIT_BIT] = limit_active_ff;
    end else if (hit_outf) begin
      rd_mux[DW-1:0] = out_freq_ff;
    end
  end

  // bus answer: zero wait states while enabled, error on unmapped address
  assign pready = clk_en;
  assign pslverr = psel && penable && !hit_any;

  // read data straight from the capture flop
  assign prdata = prdata_ff;

  // read data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= rd_mux;
    end
  end

  // register writes; polarity resets to normal error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '0;
      fixed_freq_setting_ff <= DW'(FIXED_RST);
      setpoint_value_ff <= DW'(SETPT_RST);
      pv_scale_factor_ff <= DW'(SCALE_RST);
      pid_output_limit_ff <= DW'(LIMIT_RST);
      kp_ff <= DW'(KP_RST);
      ki_ff <= DW'(KI_RST);
    end else if (wr) begin
      if (hit_ctrl) ctrl_ff <= pwdata[CTRL_W-1:0];
      if (hit_fixed) fixed_freq_setting_ff <= wdat;
      if (hit_setpt) setpoint_value_ff <= wdat;
      if (hit_scale) pv_scale_factor_ff <= wdat;
      if (hit_limit) pid_output_limit_ff <= wdat;
      if (hit_kp) kp_ff <= wdat;
      if (hit_ki) ki_ff <= wdat;
    end
  end

  // unsigned product, shifted by the fraction bits, saturated to full scale
  function automatic logic [DW-1:0] scale_sat(input logic [DW-1:0] a, input logic [DW-1:0] b);
    logic [2*DW-1:0] p;
    p = a * b;
    p = p >> FRAC_W;
    scale_sat = (|p[2*DW-1:DW]) ? FULL : p[DW-1:0];
  endfunction : scale_sat

  // signed value clamped into 0..full scale
  function automatic logic [DW-1:0] clamp_u(input logic signed [SW-1:0] v);
    logic signed [SW-1:0] fs;
    fs = $signed({{(SW-DW){1'b0}}, FULL});
    if (v < 0) clamp_u = '0;
    else if (v > fs) clamp_u = FULL;
    else clamp_u = v[DW-1:0];
  endfunction : clamp_u

  // pid on only for selector value 01
  assign pid_active = (pid_enable_sel == PID_ENABLE_ON);

  // analog terminal select, one terminal at a time
  wire logic [DW-1:0] analog_raw = (analog_sel == AIN_VOLTAGE) ? voltage_input
                                   : current_input_pin;

  // reference when the loop is idle
  wire logic [DW-1:0] ref_freq = (freq_source_sel == SRC_FIXED) ? fixed_freq_setting_ff
                               : (freq_source_sel == SRC_POT) ? pot_value
                               : (freq_source_sel == SRC_ANALOG) ? analog_raw
                               : fixed_freq_setting_ff;

  // process units to frequency units
  wire logic [DW-1:0] sp_f = scale_sat(setpoint_value_ff, pv_scale_factor_ff);
  wire logic [DW-1:0] pv_f = scale_sat(analog_raw, pv_scale_factor_ff);

  // loop error with selectable polarity
  wire logic signed [DW+1:0] err_norm = $signed({2'b00, sp_f}) - $signed({2'b00, pv_f});

  // polarity flip; two extra bits keep the negated full range
  wire logic signed [DW+1:0] err = (error_polarity_sel == POL_NORMAL) ? err_norm
                                   : -err_norm;

  // proportional and integral terms
  wire logic signed [SW-1:0] p_prod = SW'($signed({1'b0, kp_ff}) * err);
  wire logic signed [SW-1:0] i_prod = SW'($signed({1'b0, ki_ff}) * err);
  wire logic signed [SW-1:0] p_term = p_prod >>> FRAC_W;
  wire logic signed [SW-1:0] i_term = i_prod >>> FRAC_W;

  // integral sum clamped to 0..full scale so the integrator cannot wind up
  wire logic signed [SW-1:0] integ_sum = integ_ff + i_term;
  wire logic [DW-1:0] integ_next = clamp_u(integ_sum);
  wire logic signed [SW-1:0] integ_ext = $signed({{(SW-DW){1'b0}}, integ_next});

  // controller output before the limit; a negative result means stop
  wire logic [DW-1:0] ctl_raw = clamp_u(integ_ext + p_term);

  // limit band as a fraction of full scale, percent setting
  wire logic [2*DW-1:0] lim_prod = pid_output_limit_ff * FULL;
  wire logic [2*DW-1:0] lim_quot = lim_prod / (2*DW)'(PCT_FULL);
  wire logic [DW-1:0] lim_f = (|lim_quot[2*DW-1:DW]) ? FULL : lim_quot[DW-1:0];

  // a zero setting switches the limit off instead of pinning the output
  wire logic limit_on = (pid_output_limit_ff != '0);

  // deviation of controller output from setpoint
  wire logic signed [DW+1:0] dev = $signed({2'b00, ctl_raw}) - $signed({2'b00, sp_f});
  wire logic signed [DW+1:0] lim_s = $signed({2'b00, lim_f});
  wire logic over_hi = limit_on && (dev > lim_s);
  wire logic over_lo = limit_on && (dev < -lim_s);

  // pulled-back targets, saturated inside 0..full scale
  wire logic [DW:0] sp_plus = {1'b0, sp_f} + {1'b0, lim_f};
  wire logic [DW-1:0] sp_hi = sp_plus[DW] ? FULL : sp_plus[DW-1:0];
  wire logic [DW-1:0] sp_lo = (sp_f > lim_f) ? (sp_f - lim_f) : '0;

  // limited controller output
  wire logic [DW-1:0] ctl_out = over_hi ? sp_hi
                              : over_lo ? sp_lo
                              : ctl_raw;

  // frequency command selection
  wire logic [DW-1:0] nxt_out_freq = pid_active ? ctl_out : ref_freq;

  // loop step on the enabled tick; the integrator holds while the limit clips
  wire logic tick = (tick_cnt_ff == TICK_LAST);
  wire logic loop_step = clk_en && tick;
  wire logic clip_now = over_hi || over_lo;

  // loop update tick divider, so the loop rate does not depend on bus activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      tick_cnt_ff <= tick ? 16'h0000 : tick_cnt_ff + 16'h0001;
    end
  end

  // integrator: cleared while idle, frozen while the limit holds the output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_ff <= '0;
    end else if (loop_step) begin
      if (!pid_active) begin
        integ_ff <= '0;
      end else if (!clip_now) begin
        integ_ff <= integ_ext;
      end
    end
  end

  // output frequency and limit flag, updated on the tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_freq_ff <= '0;
      limit_active_ff <= 1'b0;
    end else if (loop_step) begin
      out_freq_ff <= nxt_out_freq;
      limit_active_ff <= pid_active && clip_now;
    end
  end

  // outputs straight from their flops
  assign out_freq = out_freq_ff;
  assign limit_active = limit_active_ff;

endmodule : pid_setpoint_loop

`default_nettype wire

//--- include/pid_pkg.sv
// package: register map, field layout, reset values and timing for the pid setpoint loop
package pid_pkg;

  // register byte offsets on the apb slave
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FIXED = 8'h04;
  localparam logic [7:0] REG_SETPT = 8'h08;
  localparam logic [7:0] REG_SCALE = 8'h0C;
  localparam logic [7:0] REG_LIMIT = 8'h10;
  localparam logic [7:0] REG_KP = 8'h14;
  localparam logic [7:0] REG_KI = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_OUTFREQ = 8'h20;
  localparam int ADDR_W = 8;

  // control register field positions
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_AIN_BIT = 5;
  localparam int CTRL_W = 6;

  // status register bit positions
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_LIMIT_BIT = 1;

  // pid enable selector code that turns the loop on
  localparam logic [1:0] PID_ENABLE_ON = 2'h1;

  // reference source selector codes
  localparam logic [1:0] SRC_FIXED = 2'h0;
  localparam logic [1:0] SRC_POT = 2'h1;
  localparam logic [1:0] SRC_ANALOG = 2'h2;

  // error polarity: normal for heating and ventilation, inverted for cooling
  localparam logic POL_NORMAL = 1'b0;

  // analog terminal select: voltage or current input
  localparam logic AIN_VOLTAGE = 1'b0;

  // fixed point: scale factor and gains carry this many fraction bits
  localparam int FRAC_W = 8;
  localparam logic [15:0] SCALE_RST = 16'h0100;
  localparam logic [15:0] KP_RST = 16'h0100;
  localparam logic [15:0] KI_RST = 16'h0010;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [15:0] FIXED_RST = 16'h0000;
  localparam logic [15:0] SETPT_RST = 16'h0000;

  // output limit is a percentage of full scale
  localparam int PCT_FULL = 100;

  // loop update period and clock period, both in ns
  localparam int LOOP_PERIOD_NS = 1000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOOP_TICK_CYCLES = LOOP_PERIOD_NS / CLK_PERIOD_NS;

endpackage : pid_pkg

//--- bench/pid_loop_assertions.sv
// checker: port-level properties of the pid setpoint loop
`timescale 1ns/1ns
`default_nettype none
module pid_loop_assertions
  import pid_pkg::*;
#(parameter int DW = 16, parameter int TICK_DIV = 4) (
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // samples and loop outputs
  input wire logic [DW-1:0] pot_value,
  input wire logic [DW-1:0] voltage_input,
  input wire logic [DW-1:0] current_input_pin,
  input wire logic [DW-1:0] out_freq,
  input wire logic pid_active,
  input wire logic limit_active
);
  // the six-cycle windows below need a loop tick within every four cycles
  if (TICK_DIV > 4) begin : g_bad_tick
    $error("pid_loop_assertions: TICK_DIV must be at most 4");
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] ctl_ff, fix_ff, sp_ff, sc_ff, lim_ff;
  // shadow of the settings, updated on completed writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= 32'h0;
      fix_ff <= 32'h0;
      sp_ff <= 32'h0;
      sc_ff <= 32'(SCALE_RST);
      lim_ff <= 32'h0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == REG_CTRL) ctl_ff <= pwdata;
      if (paddr == REG_FIXED) fix_ff <= pwdata;
      if (paddr == REG_SETPT) sp_ff <= pwdata;
      if (paddr == REG_SCALE) sc_ff <= pwdata;
      if (paddr == REG_LIMIT) lim_ff <= pwdata;
    end
  end
  // idle reference, scaled setpoint and its distance to the output
  wire [1:0] src_w = ctl_ff[CTRL_SRC_LSB +: 2];
  wire [DW-1:0] ain_w = ctl_ff[CTRL_AIN_BIT] ? current_input_pin : voltage_input;
  wire [DW-1:0] ref_w = src_w == SRC_POT ? pot_value : src_w == SRC_ANALOG ? ain_w : fix_ff[DW-1:0];
  wire [31:0] spr_w = (sp_ff[15:0] * sc_ff[15:0]) >> FRAC_W;
  wire [31:0] spf_w = spr_w > 32'hFFFF ? 32'hFFFF : spr_w;
  wire [31:0] of_w = 32'(out_freq);
  wire [31:0] dev_w = of_w > spf_w ? of_w - spf_w : spf_w - of_w;
  wire [31:0] lmf_w = (lim_ff[15:0] * 32'hFFFF) / PCT_FULL;
  // six steady cycles always hold one loop tick while TICK_DIV is at most 4
  sequence idle_steady;
    clk_en && !pid_active && $stable(ref_w) && $stable(ctl_ff);
  endsequence
  sequence loop_steady;
    clk_en && pid_active && $stable(sp_ff) && $stable(sc_ff) && $stable(lim_ff);
  endsequence
  AST_PID_ON: assert property (pid_active == (ctl_ff[CTRL_EN_LSB +: 2] == PID_ENABLE_ON))
    else $error("loop enable does not follow its selector");
  AST_IDLE_REF: assert property (idle_steady [*6] |-> out_freq == ref_w)
    else $error("idle output differs from the selected source");
  AST_AIN_REF: assert property (idle_steady [*6] |-> src_w != SRC_ANALOG || out_freq == ain_w)
    else $error("analog source taken from the wrong terminal");
  AST_LIMIT_IDLE: assert property (idle_steady [*6] |-> !limit_active)
    else $error("limit flag set while the loop is idle");
  AST_NO_LIMIT: assert property (loop_steady [*6] |-> lim_ff[15:0] != 0 || !limit_active)
    else $error("output clipped with no limit set");
  AST_LIMIT_BOUND: assert property (loop_steady [*6] |-> lim_ff[15:0] == 0 || dev_w <= lmf_w)
    else $error("setpoint to output deviation above the limit");
  AST_FREEZE: assert property (!clk_en |=> $stable(out_freq) && $stable(limit_active))
    else $error("loop state moved while the clock enable was low");
  AST_READY: assert property (psel && penable |-> pready == clk_en)
    else $error("ready does not follow the clock enable");
  AST_SLVERR: assert property (psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > REG_OUTFREQ))
    else $error("error response on the wrong address");
endmodule : pid_loop_assertions
`default_nettype wire

//--- bench/pid_proc_model.sv
// partner: process sensor feeding both analog terminals
`timescale 1ns/1ns
`default_nettype none
module pid_proc_model #(parameter int DW = 16) (
  // clock and the level the process sits at
  input wire logic pclk,
  input wire logic [DW-1:0] pv_level,
  // analog terminals, the current loop reads a copy with the low byte inverted
  output logic [DW-1:0] voltage_input,
  output logic [DW-1:0] current_input_pin
);
  // sensor lags the process by one cycle
  always_ff @(posedge pclk) begin
    voltage_input <= pv_level;
    current_input_pin <= pv_level ^ {{(DW-8){1'b0}}, 8'hFF};
  end
endmodule : pid_proc_model
`default_nettype wire

//--- bench/process_pid_setpoint_loop_tb_top.sv
// testbench: apb driven checks of the pid setpoint loop
`timescale 1ns/1ns
`default_nettype none
module process_pid_setpoint_loop_tb_top import pid_pkg::*;;
  localparam int TD = 4;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, pid_active;
  logic limit_active, look_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed, v;
  logic [15:0] pot_value, pv_level, voltage_input, current_input_pin, out_freq;
  logic [32:0] exp_q[$];
  logic [5:0] modes[7] = '{6'h00, 6'h04, 6'h08, 6'h28, 6'h0C, 6'h02, 6'h03};
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  pid_setpoint_loop #(.DW(16), .TICK_DIV(TD)) dut_u (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pot_value(pot_value), .voltage_input(voltage_input), .current_input_pin(current_input_pin),
    .out_freq(out_freq), .pid_active(pid_active), .limit_active(limit_active));
  pid_proc_model #(.DW(16)) proc_u (.pclk(pclk), .pv_level(pv_level),
    .voltage_input(voltage_input), .current_input_pin(current_input_pin));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // monitor: completed reads and requested looks take the oldest note
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite) chk("read", {pslverr, prdata}, exp_q.pop_front());
    if (look_req) chk("outputs", {limit_active, pid_active, 15'h0, out_freq}, exp_q.pop_front());
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd
  task automatic look(input logic [32:0] e);
    repeat (2 * TD + 2) @(posedge pclk);
    exp_q.push_back(e);
    look_req <= 1'b1;
    @(posedge pclk);
    look_req <= 1'b0;
  endtask : look
  task automatic loop(input logic [5:0] c, input logic [32:0] e);
    wr(REG_CTRL, {26'h0, c});
    look(e);
  endtask : loop
  // main sequence
  initial begin
    seed = 32'hF812;
    {presetn, clk_en, psel, penable, pwrite, look_req} = 6'b010000;
    paddr = 8'h0;
    pwdata = 32'h0;
    pot_value = 16'h0;
    pv_level = 16'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(REG_CTRL, 33'h0);
    rd(REG_SCALE, 33'h100);
    rd(8'h40, {1'b1, 32'h0});
    wr(REG_KI, 32'h0);
    // every source code, both terminals, enable codes other than 01
    foreach (modes[i]) begin
      v = $random(seed);
      pv_level <= v[15:0];
      pot_value <= v[31:16];
      wr(REG_FIXED, {16'h0, ~v[15:0]});
      case (modes[i][3:2])
        2'h1: loop(modes[i], {17'h0, v[31:16]});
        2'h2: loop(modes[i], {17'h0, modes[i][5] ? v[15:0] ^ 16'h00FF : v[15:0]});
        default: loop(modes[i], {17'h0, ~v[15:0]});
      endcase
    end
    // loop on: error, polarity, scale and terminal
    pv_level <= 16'h3000;
    wr(REG_SETPT, 32'h8000);
    loop(6'h01, 33'h0_8000_5000);
    loop(6'h11, 33'h0_8000_0000);
    pv_level <= 16'h0800;
    wr(REG_SCALE, 32'h200);
    wr(REG_SETPT, 32'h1000);
    loop(6'h01, 33'h0_8000_1000);
    pv_level <= 16'h08FF;
    loop(6'h21, 33'h0_8000_1000);
    // output limit at ten percent, then at full scale
    wr(REG_KP, 32'h0);
    wr(REG_SCALE, 32'h100);
    wr(REG_SETPT, 32'h8000);
    wr(REG_LIMIT, 32'h0A);
    loop(6'h01, 33'h1_8000_6667);
    rd(REG_STATUS, 33'h3);
    rd(REG_OUTFREQ, 33'h6667);
    wr(REG_LIMIT, 32'h64);
    loop(6'h01, 33'h0_8000_0000);
    loop(6'h00, {17'h0, ~v[15:0]});
    clk_en <= 1'b0;
    repeat (8) @(posedge pclk);
    clk_en <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(REG_CTRL, 33'h0);
    complete_run();
  end
endmodule : process_pid_setpoint_loop_tb_top
bind pid_setpoint_loop pid_loop_assertions #(.DW(DW), .TICK_DIV(TICK_DIV)) chk_u (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pot_value(pot_value), .voltage_input(voltage_input),
  .current_input_pin(current_input_pin), .out_freq(out_freq), .pid_active(pid_active),
  .limit_active(limit_active));
`default_nettype wire
